/* File: design/pyro_host_end.sv */
`timescale 1ns/1ps
module pyro_host_end #(
   parameter int UPDATE_CYC = pyro_link_pkg::UPDATE_CYC
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // request
   input  wire logic        read_req_in,
   output logic             busy_out,
   // result
   output logic [13:0]      pyro_channel_out,
   output logic [13:0]      temp_value_out,
   output logic             done_out,
   // link
   pyro_link_if.host        link
);
   typedef enum {H_IDLE, H_START, H_LOW, H_HIGH, H_SAMPLE, H_UPD} hstate_t;
   hstate_t state_reg, state_next;
   logic        s1_reg, s2_reg;
   logic [23:0] cnt_reg, cnt_next;
   logic [27:0] sh_reg, sh_next;
   logic [4:0]  bit_reg, bit_next;
   logic [27:0] out_reg, out_next;
   logic        done_reg, done_next;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
      end else begin
         s1_reg <= link.line;
         s2_reg <= s1_reg;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 24'h1;
      sh_next    = sh_reg;
      bit_next   = bit_reg;
      out_next   = out_reg;
      done_next  = 1'b0;
      case (state_reg)
         H_IDLE: begin
            cnt_next = 24'h0;
            if (read_req_in) begin
               state_next = H_START;
            end
         end
         H_START: begin
            if (cnt_reg >= 24'(pyro_link_pkg::START_HIGH_CYC)) begin
               state_next = H_LOW;
               cnt_next   = 24'h0;
               bit_next   = 5'd0;
            end
         end
         H_LOW: begin
            if (cnt_reg >= 24'(pyro_link_pkg::SETTLE_CYC)) begin
               state_next = H_HIGH;
               cnt_next   = 24'h0;
            end
         end
         H_HIGH: begin
            if (cnt_reg >= 24'(pyro_link_pkg::SETTLE_CYC)) begin
               state_next = H_SAMPLE;
               cnt_next   = 24'h0;
            end
         end
         H_SAMPLE: begin
            if (cnt_reg >= 24'(pyro_link_pkg::SETTLE_CYC)) begin
               sh_next  = {sh_reg[26:0], s2_reg};
               bit_next = bit_reg + 5'd1;
               cnt_next = 24'h0;
               if (bit_reg == 5'(pyro_link_pkg::FRAME_BITS - 1)) begin
                  state_next = H_UPD;
               end else begin
                  state_next = H_LOW;
               end
            end
         end
         H_UPD: begin
            if (cnt_reg > 24'(UPDATE_CYC)) begin
               state_next = H_IDLE;
               out_next   = sh_reg;
               done_next  = 1'b1;
            end
         end
         default: state_next = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= H_IDLE;
         cnt_reg   <= 24'h0;
         sh_reg    <= 28'h0;
         bit_reg   <= 5'd0;
         out_reg   <= 28'h0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         bit_reg   <= bit_next;
         out_reg   <= out_next;
         done_reg  <= done_next;
      end
   end

   // drive high in start/high phases, low in low/update phases, else released
   assign link.host_oe    = (state_reg == H_START) || (state_reg == H_LOW) ||
                            (state_reg == H_HIGH) || (state_reg == H_UPD);
   assign link.host_o     = (state_reg == H_START) || (state_reg == H_HIGH);
   assign busy_out        = (state_reg != H_IDLE);
   assign pyro_channel_out = out_reg[27:14];
   assign temp_value_out  = out_reg[13:0];
   assign done_out        = done_reg;
endmodule

/* File: design/pyro_sensor_end.sv */
`timescale 1ns/1ps
module pyro_sensor_end #(
   parameter int DISCHARGE_CYC  = pyro_link_pkg::DISCHARGE_CYC,
   parameter int IDLE_LIMIT_CYC = pyro_link_pkg::IDLE_LIMIT_CYC,
   parameter int UPDATE_CYC     = pyro_link_pkg::UPDATE_CYC
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // converter values
   input  wire logic [13:0] pyro_channel_in,
   input  wire logic [13:0] temp_value_in,
   // status
   output logic             discharge_out,
   output logic             refresh_out,
   // link
   pyro_link_if.dev         link
);
   typedef enum {S_IDLE, S_INT, S_WAIT, S_BIT, S_UPD} state_t;

   // line synchroniser and edge detector
   logic        s1_reg;
   logic        s1_next;
   logic        s2_reg;
   logic        s2_next;
   logic        prev_reg;
   logic        prev_next;
   logic        rise;
   logic        fall;

   // input discharge timer
   logic        out_of_range;
   logic [23:0] dis_reg;
   logic [23:0] dis_next;
   logic        dis_on_reg;
   logic        dis_on_next;

   // length of the current low phase
   logic [23:0] low_reg;
   logic [23:0] low_next;

   // link state
   state_t      state_reg;
   state_t      state_next;
   logic [23:0] idle_reg;
   logic [23:0] idle_next;
   logic [23:0] tim_reg;
   logic [23:0] tim_next;
   logic [27:0] frame_reg;
   logic [27:0] frame_next;
   logic [4:0]  bit_reg;
   logic [4:0]  bit_next;
   logic        zero_reg;
   logic        zero_next;
   logic        drive_reg;
   logic        drive_next;
   logic        upd_reg;
   logic        upd_next;

   // two flops on the line, a third for edges
   always_comb begin
      s1_next   = link.line;
      s2_next   = s1_reg;
      prev_next = s2_reg;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_reg   <= 1'b1;
         s2_reg   <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         s1_reg   <= s1_next;
         s2_reg   <= s2_next;
         prev_reg <= prev_next;
      end
   end

   assign rise = s2_reg && !prev_reg;
   assign fall = !s2_reg && prev_reg;

   // retrigger before expiry so the short stays on while out of range
   always_comb begin
      out_of_range = (pyro_channel_in < pyro_link_pkg::RANGE_LOW) ||
                     (pyro_channel_in > pyro_link_pkg::RANGE_HIGH);
      dis_next     = (dis_reg != 24'h0) ? dis_reg - 24'h1 : 24'h0;
      if (out_of_range && dis_reg <= 24'h1) begin
         dis_next = 24'(DISCHARGE_CYC);
      end
      dis_on_next  = (dis_next != 24'h0);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dis_reg    <= 24'h0;
         dis_on_reg <= 1'b0;
      end else begin
         dis_reg    <= dis_next;
         dis_on_reg <= dis_on_next;
      end
   end

   // saturating count of low cycles, cleared while the line is high
   always_comb begin
      low_next = low_reg;
      if (s2_reg) begin
         low_next = 24'h0;
      end else if (low_reg != 24'hffffff) begin
         low_next = low_reg + 24'h1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         low_reg <= 24'h0;
      end else begin
         low_reg <= low_next;
      end
   end

   // link control
   always_comb begin
      state_next = state_reg;
      idle_next  = idle_reg;
      tim_next   = (tim_reg != 24'hffffff) ? tim_reg + 24'h1 : tim_reg;
      frame_next = frame_reg;
      bit_next   = bit_reg;
      zero_next  = zero_reg;
      drive_next = 1'b0;
      upd_next   = 1'b0;
      case (state_reg)
         S_IDLE: begin
            idle_next = idle_reg + 24'h1;
            if (rise) begin
               state_next = S_WAIT;
               idle_next  = 24'h0;
            end else if (fall) begin
               // released line already high: host held it and now starts
               state_next = S_BIT;
               idle_next  = 24'h0;
               bit_next   = 5'd0;
               zero_next  = 1'b0;
            end else if (idle_reg >= 24'(IDLE_LIMIT_CYC)) begin
               state_next = S_INT;
               idle_next  = 24'h0;
            end
         end
         S_INT: begin
            drive_next = 1'b1;
            if (fall) begin
               // host pull-down starts the readout directly
               drive_next = 1'b0;
               state_next = S_BIT;
               bit_next   = 5'd0;
               zero_next  = 1'b0;
            end
         end
         S_WAIT: begin
            if (fall) begin
               state_next = S_BIT;
               bit_next   = 5'd0;
               zero_next  = 1'b0;
            end
         end
         S_BIT: begin
            // pull low only after the host has let go of its high pulse,
            // and let go again before its next rising edge
            drive_next = zero_reg &&
                         (tim_reg >= 24'(pyro_link_pkg::ZERO_ON_CYC)) &&
                         (tim_reg < 24'(pyro_link_pkg::ZERO_OFF_CYC));
            if (rise) begin
               tim_next = 24'h0;
               if (bit_reg < 5'(pyro_link_pkg::FRAME_BITS)) begin
                  zero_next = !frame_reg[5'd27 - bit_reg];
                  bit_next  = bit_reg + 5'd1;
               end else begin
                  zero_next = 1'b0;
               end
            end
            if (!s2_reg && low_reg >= 24'(UPDATE_CYC)) begin
               state_next = S_UPD;
               drive_next = 1'b0;
               zero_next  = 1'b0;
            end
         end
         S_UPD: begin
            if (s2_reg) begin
               upd_next   = 1'b1;
               frame_next = {pyro_channel_in, temp_value_in};
               state_next = S_IDLE;
               idle_next  = 24'h0;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= S_IDLE;
         idle_reg  <= 24'h0;
         tim_reg   <= 24'hffffff;
         frame_reg <= 28'h0;
         bit_reg   <= 5'd0;
         zero_reg  <= 1'b0;
         drive_reg <= 1'b0;
         upd_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         idle_reg  <= idle_next;
         tim_reg   <= tim_next;
         frame_reg <= frame_next;
         bit_reg   <= bit_next;
         zero_reg  <= zero_next;
         drive_reg <= drive_next;
         upd_reg   <= upd_next;
      end
   end

   // interrupt drives high, data bit 0 drives low
   assign link.dev_oe   = drive_reg;
   assign link.dev_o    = (state_reg == S_INT);
   assign discharge_out = dis_on_reg;
   assign refresh_out   = upd_reg;
endmodule

/* File: pkg/pyro_link_if.sv */
`timescale 1ns/1ps
interface pyro_link_if;
   logic host_oe;
   logic host_o;
   logic dev_oe;
   logic dev_o;
   logic line;
   // low wins; released line floats high
   assign line = !((host_oe && !host_o) || (dev_oe && !dev_o));
   modport host (output host_oe, output host_o, input line);
   modport dev  (output dev_oe, output dev_o, input line);
endinterface

/* File: pkg/pyro_link_pkg.sv */
package pyro_link_pkg;
   localparam int          CLK_MHZ          = 100;
   localparam int          FRAME_BITS       = 28;
   localparam int          VALUE_BITS       = 14;
   localparam int          PYRO_MSB         = 27;
   localparam int          PYRO_LSB         = 14;
   localparam int          TEMP_MSB         = 13;
   localparam int          TEMP_LSB         = 0;
   localparam logic [13:0] RANGE_LOW        = 14'd511;
   localparam logic [13:0] RANGE_HIGH       = 14'h3fff - 14'd510;
   // times in their own units
   localparam int          DISCHARGE_MS     = 16;
   localparam int          IDLE_LIMIT_US10  = 146;
   localparam int          SAMPLE_INT_MS    = 16;
   localparam int          START_HIGH_US    = 110;
   localparam int          INT_SETUP_US     = 75;
   localparam int          UPDATE_US        = 1250;
   localparam int          BIT_MAX_US       = 25;
   localparam int          SETTLE_US        = 2;
   // derived cycle counts
   localparam int          DISCHARGE_CYC    = DISCHARGE_MS * 1000 * CLK_MHZ;
   localparam int          IDLE_LIMIT_CYC   = IDLE_LIMIT_US10 * 100 * CLK_MHZ;
   localparam int          SAMPLE_INT_CYC   = SAMPLE_INT_MS * 1000 * CLK_MHZ;
   localparam int          START_HIGH_CYC   = START_HIGH_US * CLK_MHZ;
   localparam int          INT_SETUP_CYC    = INT_SETUP_US * CLK_MHZ;
   localparam int          UPDATE_CYC       = UPDATE_US * CLK_MHZ;
   localparam int          BIT_MAX_CYC      = BIT_MAX_US * CLK_MHZ;
   localparam int          SETTLE_CYC       = SETTLE_US * CLK_MHZ;
   // window after a seen rising edge in which the sensor pulls a zero low
   localparam int          ZERO_ON_CYC      = SETTLE_CYC;
   localparam int          ZERO_OFF_CYC     = SETTLE_CYC * 5 / 2;
   localparam int          CNT_W            = 24;
endpackage

/* File: tb/pyro_link_chk.sv */
`timescale 1ns/1ps
module pyro_link_chk #(
   parameter int UPDATE_CYC     = pyro_link_pkg::UPDATE_CYC,
   parameter int IDLE_LIMIT_CYC = pyro_link_pkg::IDLE_LIMIT_CYC
) (
   // link, clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic host_oe,
   input  wire logic host_o,
   input  wire logic dev_oe,
   input  wire logic dev_o,
   input  wire logic line
);
   localparam int ST = pyro_link_pkg::START_HIGH_CYC;
   localparam int BM = pyro_link_pkg::BIT_MAX_CYC;
   wire         hh = host_oe && host_o;
   wire         dh = dev_oe && dev_o;
   logic [23:0] hi_reg;
   logic [23:0] lo_reg;
   logic [23:0] idl_reg;
   logic [5:0]  nb_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // run lengths and count of host bit pulses
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hi_reg  <= 24'h0;
         lo_reg  <= 24'h0;
         idl_reg <= 24'h0;
         nb_reg  <= 6'h1c;
      end else begin
         hi_reg  <= hh ? hi_reg + 24'h1 : 24'h0;
         lo_reg  <= line ? 24'h0 : lo_reg + 24'h1;
         idl_reg <= host_oe ? 24'h0 : idl_reg + 24'h1;
         if (!hh && hi_reg != 24'h0) begin
            nb_reg <= (hi_reg >= ST) ? 6'h0 : nb_reg + 6'h1;
         end
      end
   end
   a_no_clash: assert property (!(hh && dev_oe && !dev_o))
      else $error("line driven both ways");
   a_short_low: assert property (lo_reg > BM |-> nb_reg == 6'h1c)
      else $error("line low too long in frame");
   a_update_low: assert property ($rose(line) && nb_reg == 6'h1c |-> lo_reg >= UPDATE_CYC)
      else $error("update low too short");
   a_start_len: assert property ($fell(hh) && nb_reg == 6'h1c |-> hi_reg >= ST)
      else $error("start high too short");
   a_start_low: assert property ($fell(hh) && hi_reg >= ST |-> !line)
      else $error("no low after start");
   a_bit_high: assert property ($fell(hh) && hi_reg < ST |-> hi_reg >= 20 && hi_reg <= BM)
      else $error("bad bit high time");
   a_bit_count: assert property (nb_reg <= 6'h1c)
      else $error("too many bit pulses");
   a_irq_late: assert property ($rose(dh) |-> idl_reg >= IDLE_LIMIT_CYC)
      else $error("interrupt too early");
   a_irq_due: assert property (idl_reg == IDLE_LIMIT_CYC + 16 |-> dh)
      else $error("interrupt missing");
   c_irq: cover property ($rose(dh));
   c_zero: cover property (dev_oe && !dev_o);
   c_frame: cover property ($rose(line) && nb_reg == 6'h1c);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   localparam int UPD = 500;
   localparam int IDL = 12000;
   logic        clk_in;
   logic        rst_in;
   logic        read_req_in;
   logic [13:0] pyro_in;
   logic [13:0] temp_in;
   logic        busy_out;
   logic        done_out;
   logic        discharge_out;
   logic        refresh_out;
   logic [13:0] pyro_out;
   logic [13:0] temp_out;
   logic [27:0] wire_bits;
   logic        line_q;
   logic [15:0] lfsr;
   int          num_errors;
   int          tests_run;
   int          n_ref;
   pyro_link_if lk();
   pyro_sensor_end #(.DISCHARGE_CYC(2000), .IDLE_LIMIT_CYC(IDL), .UPDATE_CYC(UPD))
   u_pyro_sensor_end (.clk_in(clk_in), .rst_in(rst_in), .pyro_channel_in(pyro_in),
      .temp_value_in(temp_in), .discharge_out(discharge_out), .refresh_out(refresh_out),
      .link(lk));
   pyro_host_end #(.UPDATE_CYC(UPD)) u_pyro_host_end (.clk_in(clk_in), .rst_in(rst_in),
      .read_req_in(read_req_in), .busy_out(busy_out), .pyro_channel_out(pyro_out),
      .temp_value_out(temp_out), .done_out(done_out), .link(lk));
   pyro_link_chk #(.UPDATE_CYC(UPD), .IDLE_LIMIT_CYC(IDL)) u_pyro_link_chk (
      .clk_in(clk_in), .rst_in(rst_in), .host_oe(lk.host_oe), .host_o(lk.host_o),
      .dev_oe(lk.dev_oe), .dev_o(lk.dev_o), .line(lk.line));
   always #5 clk_in = ~clk_in;
   always @(negedge clk_in) line_q <= lk.line;
   always @(negedge clk_in) if (refresh_out === 1'b1) n_ref++;
   // sample each bit late in the released phase
   always @(negedge lk.host_oe) begin
      if (line_q === 1'b1) begin
         repeat (150) @(negedge clk_in);
         wire_bits = {wire_bits[26:0], lk.line};
      end
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic out_rng(input logic [13:0] v);
      return v < 14'h01ff || v > 14'h3e01;
   endfunction
   task automatic step(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic frame(input logic [13:0] p, input logic [13:0] t, input logic [27:0] exp,
                        input int nf);
      int n;
      pyro_in = p;
      temp_in = t;
      read_req_in = 1'b1;
      step(1);
      read_req_in = 1'b0;
      step(3);
      check(busy_out, 1'b1);
      step(2000);
      read_req_in = 1'b1;
      step(1);
      read_req_in = 1'b0;
      n = 0;
      while (done_out !== 1'b1 && n < 40000) begin
         step(1);
         n++;
      end
      check(n < 40000, 1'b1);
      check(wire_bits, exp);
      check(pyro_out, exp[27:14]);
      check(temp_out, exp[13:0]);
      step(20);
      check(discharge_out, out_rng(p));
      check(n_ref, nf);
      check(busy_out, 1'b0);
      // one long gap lets the sensor raise its interrupt
      step((nf == 1) ? IDL + 100 : 200);
      if (nf == 1) check(lk.dev_oe && lk.dev_o, 1'b1);
   endtask
   initial begin
      logic [13:0] p;
      logic [27:0] prev;
      clk_in = 1'b0;
      rst_in = 1'b1;
      read_req_in = 1'b0;
      pyro_in = 14'h0;
      temp_in = 14'h0;
      lfsr = 16'h3a;
      num_errors = 0;
      tests_run = 0;
      n_ref = 0;
      prev = 28'h0;
      step(8);
      rst_in = 1'b0;
      check(discharge_out, 1'b0);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         p = (i == 0) ? 14'h01fe : (i == 1) ? 14'h01ff : 14'h3e02;
         frame(p, lfsr[13:0], prev, i + 1);
         prev = {p, lfsr[13:0]};
      end
      end_of_test();
   end
   initial begin
      #1500000;
      num_errors++;
      end_of_test();
   end
endmodule
